// file: design/deadband_pkg.sv
// shared constants and carrier types for the dead-band generator
package deadband_pkg;
	localparam int unsigned addr_w = 12;
	localparam int unsigned data_w = 32;
	localparam int unsigned delay_w = 16;
	localparam int unsigned num_pairs = 3;
	localparam logic [addr_w-1:0] ctrl_gen0_off = 12'h068;
	localparam logic [addr_w-1:0] rise_gen0_off = 12'h06c;
	localparam logic [addr_w-1:0] fall_gen0_off = 12'h070;
	localparam logic [addr_w-1:0] ctrl_gen1_off = 12'h0a8;
	localparam logic [addr_w-1:0] rise_gen1_off = 12'h0ac;
	localparam logic [addr_w-1:0] fall_gen1_off = 12'h0b0;
	localparam logic [addr_w-1:0] ctrl_gen2_off = 12'h0e8;
	localparam logic [addr_w-1:0] rise_gen2_off = 12'h0ec;
	localparam logic [addr_w-1:0] fall_gen2_off = 12'h0f0;
	localparam int unsigned enable_bit = 0;
	localparam logic enable_rst = 1'b0;
	localparam logic [delay_w-1:0] delay_rst = 16'h0000;
	localparam logic [data_w-1:0] unmapped_rd = 32'h0000_0000;

	// register bus request
	typedef struct packed {
		logic [addr_w-1:0] addr;
		logic [data_w-1:0] wdata;
		logic wr;
		logic rd;
	} bus_req_t;

	// per-pair configuration
	typedef struct packed {
		logic enable;
		logic [delay_w-1:0] rise;
		logic [delay_w-1:0] fall;
	} pair_cfg_t;

	// raw generator pair
	typedef struct packed {
		logic a;
		logic b;
	} raw_pair_t;
endpackage

// file: design/deadband_edge_delay.sv
// one delayed-edge channel: postpones one polarity of a level
`timescale 1ns/1ps
`default_nettype none
module deadband_edge_delay
	import deadband_pkg::*;
(
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic delay_rising,
	input wire logic level_in,
	input wire logic [deadband_pkg::delay_w-1:0] delay,
	output var logic level_out
);
	logic prev_ff;
	logic pend_ff;
	logic [delay_w-1:0] cnt_ff;
	logic target;

	// the polarity whose arrival is postponed
	assign target = delay_rising;

	// edge tracking; a new edge cancels any pending transition
	always_ff @(posedge clk)
	begin
		if (sys_rst)
		begin
			prev_ff <= 1'b0;
			pend_ff <= 1'b0;
			cnt_ff <= '0;
			level_out <= 1'b0;
		end
		else
		begin
			prev_ff <= level_in;
			if (level_in != prev_ff)
			begin
				if (level_in != target)
				begin
					// opposite edge passes at once and cancels pending
					pend_ff <= 1'b0;
					level_out <= level_in;
				end
				else if (delay == '0)
				begin
					pend_ff <= 1'b0;
					level_out <= level_in;
				end
				else
				begin
					// load the full count so d ticks add exactly d cycles over the zero-delay path
					pend_ff <= 1'b1;
					cnt_ff <= delay;
				end
			end
			else if (pend_ff)
			begin
				if (cnt_ff <= 16'h0001)
				begin
					pend_ff <= 1'b0;
					level_out <= target;
				end
				else
					cnt_ff <= cnt_ff - 16'h0001;
			end
		end
	end
endmodule
`default_nettype wire

// file: design/deadband_generator.sv
// dead-band generator for three pwm pairs with register port
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// - disabled: raw a to even output, raw b to odd output
// - enabled: raw b ignored, both outputs derived from raw a
// - enabled: even output is raw a with rising edges delayed
// - enabled: odd output is raw a with falling edges delayed
// - three identical pairs: gen0 to outputs 0/1, gen1 2/3, gen2 4/5
// - enable bit 0 of control register, read-write, resets to 0
// - control bits 31:1 reserved read-only; software preserves them
// - rise delay counts clock ticks of even-output rising lag
// - rise delay longer than high pulse swallows the even high pulse
// - fall delay counts clock ticks of odd-output falling lag
// - fall delay has no effect while disabled
// - fall delay longer than low pulse swallows the odd low pulse
module deadband_generator
	import deadband_pkg::*;
(
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic [deadband_pkg::addr_w-1:0] reg_addr,
	input wire logic [deadband_pkg::data_w-1:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output var logic [deadband_pkg::data_w-1:0] reg_rdata,
	input wire deadband_pkg::raw_pair_t [deadband_pkg::num_pairs-1:0] raw_gen,
	output var logic [2*deadband_pkg::num_pairs-1:0] pwm_out
);
	import deadband_pkg::*;

	bus_req_t req;
	pair_cfg_t [num_pairs-1:0] cfg_ff;
	logic [num_pairs-1:0] rise_lvl;
	logic [num_pairs-1:0] fall_lvl;

	assign req = '{addr: reg_addr, wdata: reg_wdata, wr: reg_wr, rd: reg_rd};

	// decode which pair a register offset belongs to, or 3 when unmapped
	function automatic logic [1:0] pair_of(input logic [addr_w-1:0] a);
		logic [1:0] p;
		p = 2'd3;
		if (a == ctrl_gen0_off || a == rise_gen0_off || a == fall_gen0_off)
			p = 2'd0;
		if (a == ctrl_gen1_off || a == rise_gen1_off || a == fall_gen1_off)
			p = 2'd1;
		if (a == ctrl_gen2_off || a == rise_gen2_off || a == fall_gen2_off)
			p = 2'd2;
		return p;
	endfunction

	// register kind: 0 ctrl, 1 rise, 2 fall, 3 none
	function automatic logic [1:0] kind_of(input logic [addr_w-1:0] a);
		logic [1:0] k;
		k = 2'd3;
		if (a == ctrl_gen0_off || a == ctrl_gen1_off || a == ctrl_gen2_off)
			k = 2'd0;
		if (a == rise_gen0_off || a == rise_gen1_off || a == rise_gen2_off)
			k = 2'd1;
		if (a == fall_gen0_off || a == fall_gen1_off || a == fall_gen2_off)
			k = 2'd2;
		return k;
	endfunction

	// register writes; reserved control bits are dropped, not stored
	always_ff @(posedge clk)
	begin
		if (sys_rst)
		begin
			for (int i = 0; i < num_pairs; i++)
			begin
				cfg_ff[i].enable <= enable_rst;
				cfg_ff[i].rise <= delay_rst;
				cfg_ff[i].fall <= delay_rst;
			end
		end
		else if (req.wr && pair_of(req.addr) != 2'd3)
		begin
			case (kind_of(req.addr))
				2'd0: cfg_ff[pair_of(req.addr)].enable <= req.wdata[enable_bit];
				2'd1: cfg_ff[pair_of(req.addr)].rise <= req.wdata[delay_w-1:0];
				2'd2: cfg_ff[pair_of(req.addr)].fall <= req.wdata[delay_w-1:0];
				default: ;
			endcase
		end
	end

	// read data one cycle after the strobe; reserved bits read zero
	always_ff @(posedge clk)
	begin
		if (sys_rst)
			reg_rdata <= unmapped_rd;
		else if (req.rd && pair_of(req.addr) != 2'd3)
		begin
			case (kind_of(req.addr))
				2'd0: reg_rdata <= {{(data_w-1){1'b0}}, cfg_ff[pair_of(req.addr)].enable};
				2'd1: reg_rdata <= {{(data_w-delay_w){1'b0}}, cfg_ff[pair_of(req.addr)].rise};
				2'd2: reg_rdata <= {{(data_w-delay_w){1'b0}}, cfg_ff[pair_of(req.addr)].fall};
				default: reg_rdata <= unmapped_rd;
			endcase
		end
		else
			reg_rdata <= unmapped_rd;
	end

	// one rising and one falling delay channel per pair
	// channels are held clear while their pair is disabled: otherwise a transition
	// pending under an old delay value would leak out once the pair is enabled,
	// so the stored delays could not be said to have no effect while disabled
	for (genvar g = 0; g < num_pairs; g++)
	begin : g_pair
		deadband_edge_delay u_rise (
			.clk(clk),
			.sys_rst(sys_rst || !cfg_ff[g].enable),
			.delay_rising(1'b1),
			.level_in(raw_gen[g].a),
			.delay(cfg_ff[g].rise),
			.level_out(rise_lvl[g])
		);
		deadband_edge_delay u_fall (
			.clk(clk),
			.sys_rst(sys_rst || !cfg_ff[g].enable),
			.delay_rising(1'b0),
			.level_in(raw_gen[g].a),
			.delay(cfg_ff[g].fall),
			.level_out(fall_lvl[g])
		);
	end

	// output select; pass-through registered once, one cycle less latency than the enabled path
	always_ff @(posedge clk)
	begin
		if (sys_rst)
			pwm_out <= '0;
		else
		begin
			for (int i = 0; i < num_pairs; i++)
			begin
				if (cfg_ff[i].enable)
				begin
					pwm_out[2*i] <= rise_lvl[i];
					pwm_out[2*i+1] <= fall_lvl[i];
				end
				else
				begin
					pwm_out[2*i] <= raw_gen[i].a;
					pwm_out[2*i+1] <= raw_gen[i].b;
				end
			end
		end
	end

	// disabled pair follows raw inputs one cycle later
	pass_a_a: assert property (@(posedge clk) disable iff (sys_rst)
		!cfg_ff[0].enable && !$past(cfg_ff[0].enable) |-> pwm_out[0] == $past(raw_gen[0].a))
		else $error("pair0 even output not pass-through");
	pass_b_a: assert property (@(posedge clk) disable iff (sys_rst)
		!cfg_ff[0].enable && !$past(cfg_ff[0].enable) |-> pwm_out[1] == $past(raw_gen[0].b))
		else $error("pair0 odd output not pass-through");
	// enabled zero-delay odd output falls with raw a two cycles on
	sequence fall_seen;
		cfg_ff[0].enable[*3] ##0 $fell(raw_gen[0].a);
	endsequence
	fall_zero_a: assert property (@(posedge clk) disable iff (sys_rst)
		fall_seen ##0 cfg_ff[0].fall == '0 |-> ##2 !pwm_out[1])
		else $error("zero fall delay not immediate");
	even_fall_a: assert property (@(posedge clk) disable iff (sys_rst)
		cfg_ff[1].enable[*3] ##0 $fell(raw_gen[1].a) |-> ##2 !pwm_out[2])
		else $error("even output falling edge delayed");
	odd_rise_a: assert property (@(posedge clk) disable iff (sys_rst)
		cfg_ff[1].enable[*3] ##0 $rose(raw_gen[1].a) |-> ##2 pwm_out[3])
		else $error("odd output rising edge delayed");
	enable_rd_a: assert property (@(posedge clk) disable iff (sys_rst)
		req.rd && req.addr == ctrl_gen2_off |=> reg_rdata == {31'h0, cfg_ff[2].enable})
		else $error("control read mismatch");
	rise_hold_a: assert property (@(posedge clk) disable iff (sys_rst)
		cfg_ff[0].enable[*3] ##0 $rose(raw_gen[0].a) ##0 cfg_ff[0].rise > 16'h0003
		##1 raw_gen[0].a[*2] |-> ##1 !pwm_out[0])
		else $error("even output rose before rise delay");
	// once pair 2 runs enabled, its odd output comes from the fall channel only
	b_ignored_a: assert property (@(posedge clk) disable iff (sys_rst)
		cfg_ff[2].enable && $past(cfg_ff[2].enable) |-> pwm_out[5] == $past(fall_lvl[2]))
		else $error("odd output moved with raw b");

	// reset leaves every output low; no disable here so that reset itself is watched
	rst_quiet_a: assert property (@(posedge clk)
		sys_rst |=> pwm_out == '0 && reg_rdata == unmapped_rd)
		else $error("outputs not cleared by reset");

	// read data stand only in the cycle after a read strobe
	rd_idle_a: assert property (@(posedge clk) disable iff (sys_rst)
		!req.rd |=> reg_rdata == unmapped_rd)
		else $error("read data outside read cycle");

	// unmapped reads answer with the idle value
	rd_stray_a: assert property (@(posedge clk) disable iff (sys_rst)
		req.rd && pair_of(req.addr) == 2'd3 |=> reg_rdata == unmapped_rd)
		else $error("unmapped read not zero");

	// a write to an unmapped offset must leave every setting alone
	stray_wr_a: assert property (@(posedge clk) disable iff (sys_rst)
		req.wr && pair_of(req.addr) == 2'd3 |=> $stable(cfg_ff))
		else $error("unmapped write changed a setting");

	// reads have no side effect on the stored settings
	rd_clean_a: assert property (@(posedge clk) disable iff (sys_rst)
		req.rd |=> $stable(cfg_ff))
		else $error("read changed a setting");

	// per-pair checks; every generator pair obeys the same rules
	for (genvar g = 0; g < num_pairs; g++)
	begin : g_chk
		// register strobes aimed at this pair, one sequence per strobe and register kind
		sequence wr_ctrl;
			req.wr && pair_of(req.addr) == 2'(g) && kind_of(req.addr) == 2'd0;
		endsequence
		sequence wr_rise;
			req.wr && pair_of(req.addr) == 2'(g) && kind_of(req.addr) == 2'd1;
		endsequence
		sequence wr_fall;
			req.wr && pair_of(req.addr) == 2'(g) && kind_of(req.addr) == 2'd2;
		endsequence
		sequence rd_ctrl;
			req.rd && pair_of(req.addr) == 2'(g) && kind_of(req.addr) == 2'd0;
		endsequence
		sequence rd_rise;
			req.rd && pair_of(req.addr) == 2'(g) && kind_of(req.addr) == 2'd1;
		endsequence
		sequence rd_fall;
			req.rd && pair_of(req.addr) == 2'(g) && kind_of(req.addr) == 2'd2;
		endsequence
		// the pair has been enabled at this edge and the one before
		sequence steady_on;
			cfg_ff[g].enable && $past(cfg_ff[g].enable);
		endsequence

		// reset brings every setting back to its reset value
		cfg_rst_a: assert property (@(posedge clk)
			sys_rst |=> cfg_ff[g].enable == enable_rst && cfg_ff[g].rise == delay_rst && cfg_ff[g].fall == delay_rst)
			else $error("settings not reset");

		// a control write lands in the enable bit on the next edge
		ctrl_wr_a: assert property (@(posedge clk) disable iff (sys_rst)
			wr_ctrl |=> cfg_ff[g].enable == $past(req.wdata[enable_bit]))
			else $error("enable bit not written");

		// a rise delay write stores the low delay bits
		rise_wr_a: assert property (@(posedge clk) disable iff (sys_rst)
			wr_rise |=> cfg_ff[g].rise == $past(req.wdata[delay_w-1:0]))
			else $error("rise delay not written");

		// a fall delay write stores the low delay bits
		fall_wr_a: assert property (@(posedge clk) disable iff (sys_rst)
			wr_fall |=> cfg_ff[g].fall == $past(req.wdata[delay_w-1:0]))
			else $error("fall delay not written");

		// settings of this pair change only by a write aimed at it
		cfg_keep_a: assert property (@(posedge clk) disable iff (sys_rst)
			!(req.wr && pair_of(req.addr) == 2'(g)) |=> $stable(cfg_ff[g]))
			else $error("setting changed without a write");

		// control reads show the enable bit and zero reserved bits
		ctrl_rd_a: assert property (@(posedge clk) disable iff (sys_rst)
			rd_ctrl |=> reg_rdata[data_w-1:1] == '0 && reg_rdata[enable_bit] == $past(cfg_ff[g].enable))
			else $error("control read wrong");

		// rise delay reads return the stored count with zero upper bits
		rise_rd_a: assert property (@(posedge clk) disable iff (sys_rst)
			rd_rise |=> reg_rdata == {{(data_w-delay_w){1'b0}}, $past(cfg_ff[g].rise)})
			else $error("rise delay read wrong");

		// fall delay reads return the stored count with zero upper bits
		fall_rd_a: assert property (@(posedge clk) disable iff (sys_rst)
			rd_fall |=> reg_rdata == {{(data_w-delay_w){1'b0}}, $past(cfg_ff[g].fall)})
			else $error("fall delay read wrong");

		// disabled pair: even output repeats raw a one cycle later
		pass_even_a: assert property (@(posedge clk) disable iff (sys_rst)
			!$past(cfg_ff[g].enable) |-> pwm_out[2*g] == $past(raw_gen[g].a))
			else $error("even pass-through wrong");

		// disabled pair: odd output repeats raw b one cycle later
		pass_odd_a: assert property (@(posedge clk) disable iff (sys_rst)
			!$past(cfg_ff[g].enable) |-> pwm_out[2*g+1] == $past(raw_gen[g].b))
			else $error("odd pass-through wrong");

		// enabled pair: even output follows the rise channel only
		even_src_a: assert property (@(posedge clk) disable iff (sys_rst)
			steady_on |-> pwm_out[2*g] == $past(rise_lvl[g]))
			else $error("even output not from rise channel");

		// enabled pair: odd output follows the fall channel only
		odd_src_a: assert property (@(posedge clk) disable iff (sys_rst)
			steady_on |-> pwm_out[2*g+1] == $past(fall_lvl[g]))
			else $error("odd output not from fall channel");

		// disabled pair keeps its channels clear
		chan_clr_a: assert property (@(posedge clk) disable iff (sys_rst)
			!cfg_ff[g].enable |=> !rise_lvl[g] && !fall_lvl[g])
			else $error("channel active while disabled");

		// zero rise delay lets the rising edge through at once
		rise_zero_a: assert property (@(posedge clk) disable iff (sys_rst)
			steady_on ##0 cfg_ff[g].rise == '0 ##0 $rose(raw_gen[g].a) |=> rise_lvl[g])
			else $error("zero rise delay held the edge");

		// zero fall delay lets the falling edge through at once
		fall_zero_a: assert property (@(posedge clk) disable iff (sys_rst)
			steady_on ##0 cfg_ff[g].fall == '0 ##0 $fell(raw_gen[g].a) |=> !fall_lvl[g])
			else $error("zero fall delay held the edge");

		// a non-zero rise delay holds the rising edge back
		rise_late_a: assert property (@(posedge clk) disable iff (sys_rst)
			steady_on ##0 cfg_ff[g].rise != '0 ##0 $rose(raw_gen[g].a) |=> !rise_lvl[g])
			else $error("rising edge not delayed");

		// a non-zero fall delay holds the falling edge back
		fall_late_a: assert property (@(posedge clk) disable iff (sys_rst)
			steady_on ##0 cfg_ff[g].fall != '0 ##0 $fell(raw_gen[g].a) |=> fall_lvl[g])
			else $error("falling edge not delayed");

		// raw a low always leaves the rise channel low, so a short pulse is swallowed
		rise_wait_a: assert property (@(posedge clk) disable iff (sys_rst)
			cfg_ff[g].enable && !raw_gen[g].a |=> !rise_lvl[g])
			else $error("rise channel high while raw a low");

		// raw a high always leaves the fall channel high, so a short gap is swallowed
		fall_wait_a: assert property (@(posedge clk) disable iff (sys_rst)
			cfg_ff[g].enable && raw_gen[g].a |=> fall_lvl[g])
			else $error("fall channel low while raw a high");
	end
endmodule
`default_nettype wire

// file: sim/gate_drv_model.sv
// gate driver model: counts turn-on edges seen at each output pin
`timescale 1ns/1ps
`default_nettype none
module gate_drv_model (
	input wire logic clk,
	input wire logic [5:0] gate_in,
	output var logic [5:0][7:0] on_cnt = '0
);
	logic [5:0] last_ff = '0;
	// a driver reacts only to turn-on, so a swallowed pulse leaves its count alone
	always @(posedge clk)
	begin
		for (int i = 0; i < 6; i++)
			if (gate_in[i] && !last_ff[i])
				on_cnt[i] <= on_cnt[i] + 8'h01;
		last_ff <= gate_in;
	end
endmodule
`default_nettype wire

// file: sim/testbench.sv
// bench for the dead-band generator: registers, pass-through, delays
`timescale 1ns/1ps
`default_nettype none
module testbench;
	import deadband_pkg::*;
	logic clk = 1'b0;
	logic sys_rst = 1'b1;
	bus_req_t req = '0;
	logic [5:0] raw = '0;
	logic [data_w-1:0] rdata;
	logic [5:0] pwm;
	logic [5:0][7:0] on_cnt;
	logic [data_w-1:0] exp_q[$];
	logic rd_d = 1'b0;
	int errors = 0;
	int tests_run = 0;
	int seed = 61;
	int cyc = 0;
	int t0 = 0;
	always #2.5 clk = ~clk;
	always @(posedge clk) cyc <= cyc + 1;
	deadband_generator uut (.clk(clk), .sys_rst(sys_rst), .reg_addr(req.addr), .reg_wdata(req.wdata),
		.reg_wr(req.wr), .reg_rd(req.rd), .reg_rdata(rdata), .raw_gen(raw), .pwm_out(pwm));
	gate_drv_model drv (.clk(clk), .gate_in(pwm), .on_cnt(on_cnt));
	task automatic cmp(input logic [data_w-1:0] got, input logic [data_w-1:0] exp);
		tests_run++;
		if (got !== exp)
		begin
			errors++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic give_verdict();
		$display("comparisons %0d mismatches %0d", tests_run, errors);
		if (errors == 0 && tests_run > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	// read data stand one cycle only, so they are taken in that cycle
	always @(posedge clk)
	begin
		if (rd_d)
			cmp(rdata, exp_q.pop_front());
		rd_d <= req.rd;
	end
	task automatic bus(input logic [addr_w-1:0] a, input logic [data_w-1:0] d, input logic w, input logic r);
		@(posedge clk);
		req <= '{a, d, w, r};
	endtask
	task automatic rd(input logic [addr_w-1:0] a, input logic [data_w-1:0] e);
		exp_q.push_back(e);
		bus(a, '0, 1'b0, 1'b1);
	endtask
	function automatic logic [addr_w-1:0] adr(input int g, input int r);
		return ctrl_gen0_off + addr_w'(64 * g + 4 * r);
	endfunction
	task automatic drive(input logic [5:0] v);
		@(posedge clk);
		raw <= v;
		t0 = cyc;
	endtask
	// pin check k edges after the last raw change, taken mid-cycle once settled
	task automatic look(input int k, input logic [5:0] m, input logic [5:0] e);
		while (cyc < t0 + k + 1)
			@(negedge clk);
		cmp({26'h0, pwm & m}, {26'h0, e & m});
	endtask
	initial
	begin
		#20000;
		errors++;
		give_verdict();
	end
	initial
	begin
		logic [31:0] w;
		logic [5:0] v;
		logic [5:0] me;
		logic [5:0] lo;
		logic [7:0] c;
		repeat (10) @(posedge clk);
		sys_rst <= 1'b0;
		for (int g = 0; g < 3; g++)
			for (int r = 0; r < 3; r++)
				rd(adr(g, r), '0);
		bus(12'h004, 32'hffff_ffff, 1'b1, 1'b0);
		rd(12'h004, unmapped_rd);
		for (int g = 0; g < 3; g++)
		begin
			bus(adr(g, 0), 32'hffff_fffe, 1'b1, 1'b0);
			rd(adr(g, 0), '0);
			bus(adr(g, 0), 32'hffff_ffff, 1'b1, 1'b0);
			rd(adr(g, 0), 32'h1);
			w = $random(seed);
			bus(adr(g, 1), w, 1'b1, 1'b0);
			rd(adr(g, 1), {16'h0, w[15:0]});
			w = $random(seed);
			bus(adr(g, 2), w, 1'b1, 1'b0);
			rd(adr(g, 2), {16'h0, w[15:0]});
			bus(adr(g, 0), '0, 1'b1, 1'b0);
		end
		bus('0, '0, 1'b0, 1'b0);
		$display("test registers done");
		// random delays stay loaded while disabled; they must not show
		for (int i = 0; i < 8; i++)
		begin
			v = 6'($random(seed));
			drive(v);
			look(1, 6'h3f, {v[4], v[5], v[2], v[3], v[0], v[1]});
		end
		$display("test pass-through done");
		for (int g = 0; g < 3; g++)
		begin
			// pairs above g are still disabled and pass raw b, so only pairs up to g are looked at
			me = 6'h01 << (2 * g);
			lo = 6'((8'h04 << (2 * g)) - 8'h01);
			bus(adr(g, 1), 32'(2 + g), 1'b1, 1'b0);
			bus(adr(g, 2), 32'(3 + g), 1'b1, 1'b0);
			bus(adr(g, 0), 32'h1, 1'b1, 1'b0);
			bus('0, '0, 1'b0, 1'b0);
			drive(6'($random(seed)) & 6'h15);
			look(8, lo, 6'h00);
			drive(6'($random(seed)) & 6'h15 | me << 1);
			look(3 + g, me, 6'h00);
			look(5 + g, lo, 6'(me * 3));
			look(20, lo, 6'(me * 3));
			drive(6'($random(seed)) & 6'h15);
			look(4 + g, me << 1, me << 1);
			look(6 + g, lo, 6'h00);
		end
		$display("test dead-band timing done");
		bus(adr(0, 1), 32'h8, 1'b1, 1'b0);
		bus(adr(0, 2), 32'h8, 1'b1, 1'b0);
		bus('0, '0, 1'b0, 1'b0);
		c = on_cnt[0];
		drive(6'h02);
		repeat (2) @(posedge clk);
		drive(6'h00);
		look(14, 6'h01, 6'h00);
		cmp({24'h0, on_cnt[0]}, {24'h0, c});
		drive(6'h02);
		look(20, 6'h03, 6'h03);
		c = on_cnt[1];
		drive(6'h00);
		repeat (2) @(posedge clk);
		drive(6'h02);
		look(14, 6'h02, 6'h02);
		cmp({24'h0, on_cnt[1]}, {24'h0, c});
		$display("test swallowed pulses done");
		bus(adr(0, 1), '0, 1'b1, 1'b0);
		bus(adr(0, 2), '0, 1'b1, 1'b0);
		bus('0, '0, 1'b0, 1'b0);
		drive(6'h00);
		look(3, 6'h03, 6'h00);
		drive(6'h02);
		look(3, 6'h03, 6'h03);
		$display("test zero delay done");
		give_verdict();
	end
endmodule
`default_nettype wire
